// *** core/slhs_counter.sv ***
// 13-stage run-enabled counter with restart and mid-count strobe
`timescale 1ns/1ps
module slhs_counter (
    input wire logic clock,
    input wire logic reset,
    input wire logic restart,
    input wire logic run,
    output logic [12:0] count,
    output logic midCount
);
    logic [12:0] count_reg;
    always_ff @(posedge clock) begin
        if (reset || restart) begin
            count_reg <= 13'h0000;
        end else if (run) begin
            count_reg <= count_reg + 13'h0001;
        end
    end
    assign count = count_reg;
    // pulse when counter holds last value before mid-count
    assign midCount = run && !restart && (count_reg == (slhs_pkg::MID_COUNT - 13'h0001));
endmodule

// *** core/slhs_pkg.sv ***
// package: register map, field layout, states and counts for the stop-exit sequencer
package slhs_pkg;
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_SAVED = 12'h004;
    localparam logic [11:0] REG_FLAG = 12'h008;
    localparam logic [11:0] REG_CMD = 12'h00C;
    // control register fields
    localparam int CTRL_NOLIMP = 0;
    localparam int CTRL_CME = 1;
    localparam int CTRL_FORCED_CLOCK_MONITOR_ENABLE = 2;
    localparam int CTRL_DELAY = 3;
    localparam int CTRL_PSTOP = 4;
    localparam int CTRL_LIMP_HOME_INTERRUPT_ENABLE = 5;
    localparam int CTRL_BCPS = 6;
    localparam int CTRL_MCS = 7;
    localparam int CTRL_AUTO = 8;
    localparam logic [8:0] CTRL_RESET = 9'h000;
    // flag register fields
    localparam int FLAG_LIMP_HOME_STATUS_FLAG = 0;
    localparam int FLAG_LIMP_HOME_INTERRUPT_FLAG = 1;
    localparam int FLAG_STOPPED = 2;
    localparam int FLAG_PSTOPPED = 3;
    localparam int FLAG_RUNNING = 4;
    // command register fields
    localparam int CMD_STOP = 0;
    localparam int CMD_CLR_LIMP_HOME_INTERRUPT_FLAG = 1;
    // counter timing
    localparam int COUNTER_STAGES = 13;
    localparam int STAB_COUNT = 4096;
    localparam logic [12:0] MID_COUNT = 13'h1000;
    localparam logic [12:0] FIRST_CHECK = 13'h0FFF;
    typedef enum logic [5:0] {
        ST_RUN = 6'h01,
        ST_STOP = 6'h02,
        ST_DELAY = 6'h04,
        ST_LIMP = 6'h08,
        ST_CMRESET = 6'h10,
        ST_PSTOP = 6'h20
    } slhs_state_t;
    typedef struct packed {
        logic busClockPllSelect;
        logic moduleClockSelect;
        logic pllOn;
        logic useFallback;
        logic forcedMonitor;
    } slhs_clk_t;
    typedef struct packed {
        logic externalReset;
        logic irqPin;
        logic nonmaskableInterruptPin;
        logic keyPortJ;
        logic keyPortH;
        logic canWake;
    } slhs_wake_t;
endpackage

// *** core/slhs_sequencer.sv ***
// stop, pseudo-stop exit and limp-home sequencer with APB register slave
// How it works
// R1 - no limp-home, monitors off: stop, then wake on external clock
// R2 - delay set: resume only after 4096 module-clock cycles from wake-up
// R3 - software sets delay before stop when limp-home disabled
// R4 - no limp-home with monitor enabled: stop means monitor failure reset
// R5 - limp-home enabled: monitor enables masked during stop
// R6 - leaving stop with limp-home enabled enters limp-home, monitors forced on
// R7 - delay set: fallback clock counts 4096, external clock present then exits
// R8 - no clock after first 4096: exit in limp-home, status and interrupt set
// R9 - in limp-home check monitor at mid-count, every 8192 cycles
// R10 - clock found: leave limp-home, clear status, set interrupt flag
// R11 - limp-home, delay clear: release stop at once, run in limp-home
// R12 - fast recovery with crystal not recommended for software
// R13 - leaving limp-home restores saved bus and module clock selects
// R14 - auto and pll select saved set: relock pll after limp-home
// R15 - software clears pll select while still in limp-home
// R16 - external clock present, delay clear: release at once, status never set
// R17 - pseudo-stop select makes stop enter pseudo-stop, oscillator kept running
// R18 - wake on reset pin, interrupt pins, key ports or can wake
// R19 - pseudo-stop exit with delay: limp-home, fallback clock, forced selects
// R20 - after 4096 exit on crystal, else fallback with flags set
// R21 - delay bit picks 4096 count or none
// R22 - any status change sets interrupt flag; status in flag register
// R23 - interrupt flag sticky until software clears it
// R24 - counter restarted at each delay start
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
module slhs_sequencer (
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stopInstruction,
    input wire slhs_pkg::slhs_wake_t wake,
    input wire logic externalClockPresent,
    output slhs_pkg::slhs_clk_t clockSelect,
    output logic cpuHalted,
    output logic clockMonitorReset,
    output logic oscillatorLowAmplitude,
    output logic pllRelock,
    output logic limpHomeInterrupt
);
    slhs_pkg::slhs_state_t state_reg;
    slhs_pkg::slhs_state_t state_next;
    logic [8:0] ctrl_reg;
    logic limpHomeStatus_reg;
    logic limpHomeIrqFlag_reg;
    logic savedBcps_reg;
    logic savedMcs_reg;
    logic savedAuto_reg;
    logic fromPseudo_reg;
    logic [31:0] prdata_reg;
    logic clockMonitorReset_reg;
    logic pllRelock_reg;
    logic midCount;
    logic restartCount;
    logic anyWake;
    logic monitorEnabled;
    logic apbWrite;
    logic apbRead;
    logic stopRequest;
    logic leaveLimp;
    logic enterLimp;
    logic firstDone;

    function automatic logic mapped(input logic [11:0] addr);
        mapped = (addr == slhs_pkg::REG_CTRL) || (addr == slhs_pkg::REG_SAVED) ||
                 (addr == slhs_pkg::REG_FLAG) || (addr == slhs_pkg::REG_CMD);
    endfunction

    assign apbWrite = psel && penable && pwrite;
    assign apbRead = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign stopRequest = stopInstruction ||
                         (apbWrite && paddr == slhs_pkg::REG_CMD && pwdata[slhs_pkg::CMD_STOP]);
    // R18 wake sources
    assign anyWake = |wake;
    assign monitorEnabled = ctrl_reg[slhs_pkg::CTRL_CME] || ctrl_reg[slhs_pkg::CTRL_FORCED_CLOCK_MONITOR_ENABLE];
    // R24 restart at each delay start
    assign restartCount = (state_reg != slhs_pkg::ST_DELAY) && (state_next == slhs_pkg::ST_DELAY);

    slhs_counter counter (
        .clock(clock),
        .reset(reset),
        .restart(restartCount),
        .run(state_reg == slhs_pkg::ST_DELAY || state_reg == slhs_pkg::ST_LIMP),
        .count(),
        .midCount(midCount)
    );
    // R2 first 4096 counted
    assign firstDone = midCount;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            slhs_pkg::ST_RUN: begin
                if (stopRequest) begin
                    // R4 stop without limp-home and monitor on
                    if (ctrl_reg[slhs_pkg::CTRL_NOLIMP] && monitorEnabled) begin
                        state_next = slhs_pkg::ST_CMRESET;
                    // R17 pseudo-stop select
                    end else if (ctrl_reg[slhs_pkg::CTRL_PSTOP]) begin
                        state_next = slhs_pkg::ST_PSTOP;
                    end else begin
                        state_next = slhs_pkg::ST_STOP;
                    end
                end
            end
            slhs_pkg::ST_STOP, slhs_pkg::ST_PSTOP: begin
                if (anyWake) begin
                    // R21 delay select
                    if (ctrl_reg[slhs_pkg::CTRL_DELAY]) begin
                        state_next = slhs_pkg::ST_DELAY;
                    // R1 no limp-home waits on external clock
                    end else if (ctrl_reg[slhs_pkg::CTRL_NOLIMP]) begin
                        state_next = externalClockPresent ? slhs_pkg::ST_RUN : state_reg;
                    // R16 external clock fast exit
                    end else if (externalClockPresent) begin
                        state_next = slhs_pkg::ST_RUN;
                    // R11 fast recovery in limp-home
                    end else begin
                        state_next = slhs_pkg::ST_LIMP;
                    end
                end
            end
            slhs_pkg::ST_DELAY: begin
                if (firstDone) begin
                    // R7 R20 exit on external clock
                    if (externalClockPresent) begin
                        state_next = slhs_pkg::ST_RUN;
                    // R8 exit in limp-home
                    end else if (!ctrl_reg[slhs_pkg::CTRL_NOLIMP]) begin
                        state_next = slhs_pkg::ST_LIMP;
                    end else begin
                        state_next = slhs_pkg::ST_DELAY;
                    end
                end
            end
            slhs_pkg::ST_LIMP: begin
                // R9 mid-count check
                if (midCount && externalClockPresent) begin
                    state_next = slhs_pkg::ST_RUN;
                end
            end
            slhs_pkg::ST_CMRESET: begin
                if (externalClockPresent) begin
                    state_next = slhs_pkg::ST_RUN;
                end
            end
            default: begin
                state_next = slhs_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg <= slhs_pkg::ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    assign enterLimp = (state_reg != slhs_pkg::ST_LIMP) && (state_next == slhs_pkg::ST_LIMP);
    assign leaveLimp = (state_reg == slhs_pkg::ST_LIMP) && (state_next == slhs_pkg::ST_RUN);

    always_ff @(posedge clock) begin
        if (reset) begin
            fromPseudo_reg <= 1'b0;
        end else if (state_reg == slhs_pkg::ST_RUN && state_next == slhs_pkg::ST_PSTOP) begin
            fromPseudo_reg <= 1'b1;
        end else if (state_reg == slhs_pkg::ST_RUN && state_next == slhs_pkg::ST_STOP) begin
            fromPseudo_reg <= 1'b0;
        end
    end

    // control register, software side; selects restored on limp-home exit
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_reg <= slhs_pkg::CTRL_RESET;
        end else if (leaveLimp) begin
            // R13 restore saved selects
            ctrl_reg[slhs_pkg::CTRL_BCPS] <= savedBcps_reg;
            ctrl_reg[slhs_pkg::CTRL_MCS] <= savedMcs_reg;
        end else if (apbWrite && paddr == slhs_pkg::REG_CTRL) begin
            ctrl_reg <= pwdata[8:0];
        end
    end

    // saved selects; software may clear saved pll select during limp-home
    always_ff @(posedge clock) begin
        if (reset) begin
            savedBcps_reg <= 1'b0;
            savedMcs_reg <= 1'b0;
            savedAuto_reg <= 1'b0;
        end else if (enterLimp || restartCount) begin
            savedBcps_reg <= ctrl_reg[slhs_pkg::CTRL_BCPS];
            savedMcs_reg <= ctrl_reg[slhs_pkg::CTRL_MCS];
            savedAuto_reg <= ctrl_reg[slhs_pkg::CTRL_AUTO];
        // R15 software clear of pll select in limp-home
        end else if (apbWrite && paddr == slhs_pkg::REG_SAVED) begin
            savedBcps_reg <= pwdata[0];
            savedMcs_reg <= pwdata[1];
            savedAuto_reg <= pwdata[2];
        end
    end

    // status flag and sticky interrupt flag
    always_ff @(posedge clock) begin
        if (reset) begin
            limpHomeStatus_reg <= 1'b0;
        // R8 R11 status set on limp-home entry
        end else if (enterLimp) begin
            limpHomeStatus_reg <= 1'b1;
        // R10 status cleared on exit
        end else if (leaveLimp) begin
            limpHomeStatus_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            limpHomeIrqFlag_reg <= 1'b0;
        // R22 R10 any status change sets flag, set wins over clear
        end else if (enterLimp || leaveLimp) begin
            limpHomeIrqFlag_reg <= 1'b1;
        // R23 cleared only by software
        end else if (apbWrite && paddr == slhs_pkg::REG_CMD && pwdata[slhs_pkg::CMD_CLR_LIMP_HOME_INTERRUPT_FLAG]) begin
            limpHomeIrqFlag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            clockMonitorReset_reg <= 1'b0;
        // R4 monitor failure reset request
        end else begin
            clockMonitorReset_reg <= (state_next == slhs_pkg::ST_CMRESET);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            pllRelock_reg <= 1'b0;
        // R14 relock when auto and pll select were set
        end else begin
            pllRelock_reg <= leaveLimp && savedAuto_reg && savedBcps_reg;
        end
    end

    always_comb begin
        // R6 R19 forced clock selects while on fallback clock
        if (state_reg == slhs_pkg::ST_LIMP ||
            (state_reg == slhs_pkg::ST_DELAY && !ctrl_reg[slhs_pkg::CTRL_NOLIMP])) begin
            clockSelect.busClockPllSelect = 1'b1;
            clockSelect.moduleClockSelect = 1'b0;
            clockSelect.pllOn = 1'b1;
            clockSelect.useFallback = 1'b1;
            clockSelect.forcedMonitor = 1'b1;
        end else begin
            clockSelect.busClockPllSelect = ctrl_reg[slhs_pkg::CTRL_BCPS];
            clockSelect.moduleClockSelect = ctrl_reg[slhs_pkg::CTRL_MCS];
            clockSelect.pllOn = ctrl_reg[slhs_pkg::CTRL_BCPS];
            clockSelect.useFallback = 1'b0;
            // R5 monitor enables masked during stop
            clockSelect.forcedMonitor = monitorEnabled &&
                !(state_reg == slhs_pkg::ST_STOP || state_reg == slhs_pkg::ST_PSTOP);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            prdata_reg <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                slhs_pkg::REG_CTRL: prdata_reg <= {23'h000000, ctrl_reg};
                slhs_pkg::REG_SAVED: prdata_reg <= {29'h00000000, savedAuto_reg, savedMcs_reg, savedBcps_reg};
                slhs_pkg::REG_FLAG: prdata_reg <= {27'h0000000, state_reg == slhs_pkg::ST_RUN,
                    state_reg == slhs_pkg::ST_PSTOP, state_reg == slhs_pkg::ST_STOP,
                    limpHomeIrqFlag_reg, limpHomeStatus_reg};
                default: prdata_reg <= 32'h00000000;
            endcase
        end
    end

    assign prdata = apbRead ? prdata_reg : 32'h00000000;
    // R2 cpu held through stop and delay
    assign cpuHalted = (state_reg == slhs_pkg::ST_STOP) || (state_reg == slhs_pkg::ST_PSTOP) ||
                       (state_reg == slhs_pkg::ST_DELAY) || (state_reg == slhs_pkg::ST_CMRESET);
    assign oscillatorLowAmplitude = (state_reg == slhs_pkg::ST_PSTOP);
    assign clockMonitorReset = clockMonitorReset_reg;
    assign pllRelock = pllRelock_reg;
    assign limpHomeInterrupt = limpHomeIrqFlag_reg && ctrl_reg[slhs_pkg::CTRL_LIMP_HOME_INTERRUPT_ENABLE];
    // fromPseudo is not in any readback; only tied to an unused signal
    logic unusedPseudo;
    assign unusedPseudo = fromPseudo_reg;
endmodule

// *** test/slhs_clock_source.sv ***
// partner: crystal source with start-up time and monitor output
`timescale 1ns/1ps
module slhs_clock_source #(parameter int STARTUP = 16) (
    input wire logic clock,
    input wire logic reset,
    input wire logic crystalOn,
    output logic present
);
    int settle;
    always_ff @(posedge clock) begin
        if (reset || !crystalOn) begin
            settle <= 0;
            present <= 1'b0;
        end else if (settle < STARTUP) begin
            settle <= settle + 1;
        end else begin
            present <= 1'b1;
        end
    end
endmodule

// *** test/slhs_sequencer_monitor.sv ***
// checker: timing relations at the sequencer ports
`timescale 1ns/1ps
module slhs_sequencer_monitor (
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic stopInstruction,
    input wire slhs_pkg::slhs_wake_t wake,
    input wire logic externalClockPresent,
    input wire slhs_pkg::slhs_clk_t clockSelect,
    input wire logic cpuHalted,
    input wire logic clockMonitorReset,
    input wire logic oscillatorLowAmplitude,
    input wire logic pllRelock,
    input wire logic limpHomeInterrupt
);
    logic [8:0] ctrlShadow;
    logic [15:0] sinceWake;
    logic apbWrite, noLimp, monOn, delaySel, pstopSel, lhieSel, stopTaken;
    assign apbWrite = psel && penable && pwrite;
    assign noLimp = ctrlShadow[slhs_pkg::CTRL_NOLIMP];
    assign monOn = ctrlShadow[slhs_pkg::CTRL_CME] || ctrlShadow[slhs_pkg::CTRL_FORCED_CLOCK_MONITOR_ENABLE];
    assign delaySel = ctrlShadow[slhs_pkg::CTRL_DELAY];
    assign pstopSel = ctrlShadow[slhs_pkg::CTRL_PSTOP];
    assign lhieSel = ctrlShadow[slhs_pkg::CTRL_LIMP_HOME_INTERRUPT_ENABLE];
    assign stopTaken = stopInstruction && !cpuHalted && !clockSelect.useFallback;
    // shadow of the control register seen on the bus
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrlShadow <= 9'h000;
        end else if (apbWrite && paddr == slhs_pkg::REG_CTRL) begin
            ctrlShadow <= pwdata[8:0];
        end
    end
    // cycles since the last wake event
    always_ff @(posedge clock) begin
        if (reset || $rose(|wake)) begin
            sinceWake <= 16'h0000;
        end else if (sinceWake != 16'hFFFF) begin
            sinceWake <= sinceWake + 16'h0001;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    a_monitor_fail_reset: assert property (stopTaken && noLimp && monOn |-> ##[1:3] clockMonitorReset)
        else $error("stop with monitor on did not reset");
    a_monitor_masked: assert property (stopTaken && !noLimp |-> ##1 (!clockMonitorReset) [*3])
        else $error("monitor reset despite limp-home enabled");
    a_pseudo_stop_osc: assert property (stopTaken && pstopSel && !(noLimp && monOn) |->
        ##[1:2] oscillatorLowAmplitude)
        else $error("pseudo-stop not entered");
    a_delay_count_held: assert property ($fell(cpuHalted) && delaySel && !clockMonitorReset |->
        sinceWake >= 16'h0FFE)
        else $error("stop released before delay count");
    a_fast_release: assert property ($rose(|wake) && cpuHalted && !delaySel && !noLimp |-> ##[1:4] !cpuHalted)
        else $error("fast recovery not released at once");
    a_limp_forced: assert property (clockSelect.useFallback |->
        clockSelect.forcedMonitor && clockSelect.busClockPllSelect && !clockSelect.moduleClockSelect)
        else $error("fallback clock without forced selects");
    a_irq_sticky: assert property (limpHomeInterrupt && !apbWrite |=> limpHomeInterrupt)
        else $error("interrupt dropped without software");
    a_relock_pulse: assert property (pllRelock |-> !clockSelect.useFallback ##1 !pllRelock)
        else $error("relock pulse malformed");
    a_limp_exit_flag: assert property ($fell(clockSelect.useFallback) && !$past(cpuHalted) |->
        ##[0:2] (limpHomeInterrupt || !lhieSel))
        else $error("no interrupt on limp-home exit");
    a_unmapped_err: assert property (psel && penable && paddr > slhs_pkg::REG_CMD |-> pslverr)
        else $error("unmapped access without error");
endmodule

// *** test/tb_slhs_sequencer.sv ***
// testbench: stop, wake and limp-home sequences over the bus
`timescale 1ns/1ps
module tb_slhs_sequencer;
    logic clock, reset, psel, penable, pwrite, pready, pslverr, stopInstruction, crystalOn, errBit, relockSeen;
    logic cpuHalted, clockMonitorReset, oscillatorLowAmplitude, pllRelock, limpHomeInterrupt, externalClockPresent;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    slhs_pkg::slhs_wake_t wake;
    slhs_pkg::slhs_clk_t clockSelect;
    int errors, tests_run, n, cyc, tLimp;
    always #2 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    slhs_sequencer dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .stopInstruction(stopInstruction), .wake(wake), .externalClockPresent(externalClockPresent),
        .clockSelect(clockSelect), .cpuHalted(cpuHalted), .clockMonitorReset(clockMonitorReset),
        .oscillatorLowAmplitude(oscillatorLowAmplitude), .pllRelock(pllRelock),
        .limpHomeInterrupt(limpHomeInterrupt));
    slhs_clock_source #(.STARTUP(16)) xtal (.clock(clock), .reset(reset), .crystalOn(crystalOn),
        .present(externalClockPresent));
    task automatic test_done;
        if (errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expected);
        tests_run++;
        if (seen !== expected) begin
            errors++;
            $display("Error %s expected %h seen %h", name, expected, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        errBit = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic do_stop;
        stopInstruction <= 1'b1;
        @(posedge clock);
        stopInstruction <= 1'b0;
        repeat (3) @(posedge clock);
    endtask
    task automatic do_wake(input logic [5:0] src);
        wake <= slhs_pkg::slhs_wake_t'(src);
        @(posedge clock);
        wake <= slhs_pkg::slhs_wake_t'(6'h00);
    endtask
    task automatic wait_run(output int c);
        c = 0;
        while (cpuHalted !== 1'b0 && c < 20000) begin
            @(posedge clock);
            c++;
        end
    endtask
    task automatic wait_limp_exit(output int c);
        c = 0;
        relockSeen = 1'b0;
        while (clockSelect.useFallback !== 1'b0 && c < 9000) begin
            @(posedge clock);
            c++;
            relockSeen = relockSeen | pllRelock;
        end
        check("limp exit", 32'(clockSelect.useFallback), 32'h0);
        repeat (3) begin
            @(posedge clock);
            relockSeen = relockSeen | pllRelock;
        end
    endtask
    initial begin
        #(4 * 60000);
        errors++;
        test_done;
    end
    initial begin
        clock = 1'b0;
        reset = 1'b1;
        {psel, penable, pwrite, stopInstruction} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        wake = slhs_pkg::slhs_wake_t'(6'h00);
        crystalOn = 1'b1;
        errors = 0;
        tests_run = 0;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        repeat (20) @(posedge clock);
        apb(1'b0, slhs_pkg::REG_CTRL, 32'h0);
        check("ctrl reset", rd, 32'(slhs_pkg::CTRL_RESET));
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped error", 32'(errBit), 32'h1);
        check("unmapped data", rd, 32'h0);
        apb(1'b1, slhs_pkg::REG_CTRL, 32'h9);
        do_stop;
        do_wake(6'h02);
        wait_run(n);
        check("delay exit", 32'(n >= 4094 && n <= 4100), 32'h1);
        apb(1'b1, slhs_pkg::REG_CTRL, 32'h1);
        for (int i = 0; i < 6; i++) begin
            do_stop;
            do_wake(6'h01 << i);
            wait_run(n);
            check("wake source", 32'(n < 8), 32'h1);
        end
        apb(1'b1, slhs_pkg::REG_CTRL, 32'h5);
        crystalOn <= 1'b0;
        do_stop;
        check("monitor reset", 32'(clockMonitorReset), 32'h1);
        crystalOn <= 1'b1;
        wait_run(n);
        check("monitor reset exit", 32'(clockMonitorReset), 32'h0);
        apb(1'b1, slhs_pkg::REG_CTRL, 32'h1EA);
        crystalOn <= 1'b0;
        do_stop;
        check("monitor masked", 32'(clockMonitorReset), 32'h0);
        do_wake(6'h04);
        wait_run(n);
        tLimp = cyc;
        check("limp fallback", 32'(clockSelect.useFallback), 32'h1);
        check("forced monitor", 32'(clockSelect.forcedMonitor), 32'h1);
        check("pll forced on", 32'(clockSelect.pllOn), 32'h1);
        apb(1'b0, slhs_pkg::REG_FLAG, 32'h0);
        check("flags in limp", rd & 32'h3, 32'h3);
        check("limp interrupt", 32'(limpHomeInterrupt), 32'h1);
        apb(1'b1, slhs_pkg::REG_CMD, 32'h2);
        check("interrupt cleared", 32'(limpHomeInterrupt), 32'h0);
        crystalOn <= 1'b1;
        wait_limp_exit(n);
        check("check interval", 32'(cyc - tLimp - 3 >= 8190 && cyc - tLimp - 3 <= 8194), 32'h1);
        check("pll relock", 32'(relockSeen), 32'h1);
        check("exit interrupt", 32'(limpHomeInterrupt), 32'h1);
        apb(1'b0, slhs_pkg::REG_FLAG, 32'h0);
        check("flags after limp", rd & 32'h3, 32'h2);
        check("module select restored", 32'(clockSelect.moduleClockSelect), 32'h1);
        check("pll select restored", 32'(clockSelect.busClockPllSelect), 32'h1);
        apb(1'b1, slhs_pkg::REG_CMD, 32'h2);
        apb(1'b1, slhs_pkg::REG_CTRL, 32'h140);
        do_stop;
        do_wake(6'h08);
        wait_run(n);
        check("fast exit", 32'(n < 5), 32'h1);
        apb(1'b0, slhs_pkg::REG_FLAG, 32'h0);
        check("status never set", rd & 32'h1, 32'h0);
        crystalOn <= 1'b0;
        do_stop;
        do_wake(6'h10);
        wait_run(n);
        check("fast limp exit", 32'(n < 5), 32'h1);
        check("fast limp fallback", 32'(clockSelect.useFallback), 32'h1);
        apb(1'b1, slhs_pkg::REG_SAVED, 32'h4);
        crystalOn <= 1'b1;
        wait_limp_exit(n);
        check("pll select cleared", 32'(clockSelect.busClockPllSelect), 32'h0);
        check("no relock", 32'(relockSeen), 32'h0);
        apb(1'b1, slhs_pkg::REG_CMD, 32'h2);
        apb(1'b1, slhs_pkg::REG_CTRL, 32'h98);
        do_stop;
        check("pseudo-stop entered", 32'(oscillatorLowAmplitude), 32'h1);
        do_wake(6'h20);
        repeat (4) @(posedge clock);
        check("pseudo pll forced", 32'(clockSelect.busClockPllSelect), 32'h1);
        check("pseudo module forced", 32'(clockSelect.moduleClockSelect), 32'h0);
        wait_run(n);
        check("pseudo delay", 32'(n + 4 >= 4094 && n + 4 <= 4100), 32'h1);
        apb(1'b0, slhs_pkg::REG_FLAG, 32'h0);
        check("pseudo exit on crystal", rd & 32'h1, 32'h0);
        check("pseudo module restored", 32'(clockSelect.moduleClockSelect), 32'h1);
        test_done;
    end
endmodule
bind slhs_sequencer slhs_sequencer_monitor mon (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stopInstruction(stopInstruction), .wake(wake), .externalClockPresent(externalClockPresent),
    .clockSelect(clockSelect), .cpuHalted(cpuHalted), .clockMonitorReset(clockMonitorReset),
    .oscillatorLowAmplitude(oscillatorLowAmplitude), .pllRelock(pllRelock), .limpHomeInterrupt(limpHomeInterrupt));
